// file: core/opp_program_start_n_port.v
`timescale 1ns/1ns
`include "opp_defs.vh"
// Programming port of the on-chip OTP array
module opp_program_start_n_port #(
  parameter AW = 12
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_b_i,
  // Mode straps
  input wire external_access_n_i,
  input wire [3:0] program_algorithm_select_i,
  // Slave strobes
  input wire program_start_n_cmd_latch_n_i,
  input wire program_start_n_i,
  input wire auto_address_step_n_i,
  // Program bus, open drain, oe low means pulling low
  input wire [15:0] program_bus_i,
  output reg [15:0] program_bus_o,
  output reg [15:0] program_bus_oe_n_o,
  // Auto mode memory fetch strobe
  output reg fetch_rd_n_o,
  // Status
  output reg word_verify_ok_o,
  output reg cumulative_verify_ok_o,
  output reg programming_active_n_o,
  output reg program_start_n_mode_o
);
  localparam ST_IDLE = 3'd0;
  localparam ST_PULSE = 3'd1;
  localparam ST_VERIFY = 3'd2;
  localparam ST_AFETCH = 3'd3;
  localparam ST_ADATA = 3'd4;
  localparam ST_DONE = 3'd5;
  localparam [7:0] PULSE_CYC = `OPP_PULSE_CYC;

  wire [3:0] s_in;
  wire [3:0] s_q;
  wire [15:0] bus_s;
  wire cmd_n_s;
  wire program_start_n_n_s;
  wire step_n_s;
  wire ea_n_s;
  wire [15:0] rdata;

  reg started_q;
  reg [1:0] boot_q;
  reg [3:0] alg_q;
  reg slave_q;
  reg auto_q;
  reg cmd_n_old_q;
  reg program_start_n_n_old_q;
  reg [2:0] st_q;
  reg [15:0] addr_q;
  reg [15:0] wdata_q;
  reg [3:0] cmd_q;
  reg [7:0] cnt_q;
  reg wr_q;
  reg read_drv_q;

  // strobes and straps pass two flip-flops
  opp_sync #(.W(4)) u_sync_ctl (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i(s_in),
    .q_o(s_q)
  );
  assign s_in = {external_access_n_i, auto_address_step_n_i,
                 program_start_n_i, program_start_n_cmd_latch_n_i};
  assign cmd_n_s = s_q[0];
  assign program_start_n_n_s = s_q[1];
  assign step_n_s = s_q[2];
  assign ea_n_s = s_q[3];

  // Bus and select pins synchronised as well
  opp_sync #(.W(16)) u_sync_bus (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i(program_bus_i),
    .q_o(bus_s)
  );
  wire [3:0] alg_s;
  opp_sync #(.W(4)) u_sync_alg (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .d_i(program_algorithm_select_i),
    .q_o(alg_s)
  );

  opp_array #(.AW(AW)) u_array (
    .clock_i(clock_i),
    .wr_i(wr_q),
    .addr_i(addr_q[AW-1:0]),
    .wdata_i(wdata_q),
    .rdata_o(rdata)
  );

  // Command is taken as the latch strobe ends, once any read drive is off
  wire cmd_rise = ~cmd_n_old_q & cmd_n_s;
  wire program_start_n_rise = ~program_start_n_n_old_q & program_start_n_n_s;
  wire program_start_n_fall = program_start_n_n_old_q & ~program_start_n_n_s;
  wire verify_ok = (rdata == wdata_q);

  // Mode capture once after reset release
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      started_q <= 1'b0;
      boot_q <= 2'd0;
      alg_q <= 4'h0;
      slave_q <= 1'b0;
      auto_q <= 1'b0;
      program_start_n_mode_o <= 1'b0;
      cmd_n_old_q <= 1'b1;
      program_start_n_n_old_q <= 1'b1;
    end else begin
      cmd_n_old_q <= cmd_n_s;
      program_start_n_n_old_q <= program_start_n_n_s;
      // Wait until the straps have passed both synchroniser stages
      if (!started_q && boot_q != 2'd2) begin
        boot_q <= boot_q + 2'd1;
      end else if (!started_q) begin
        started_q <= 1'b1;
        // Select held stable by the far side during the mode
        alg_q <= alg_s;
        if (!ea_n_s) begin
          program_start_n_mode_o <= 1'b1;
          slave_q <= (alg_s == `OPP_ALG_SLAVE) ||
                     (alg_s == `OPP_ALG_DUMP);
          auto_q <= (alg_s == `OPP_ALG_AUTO);
        end
      end
    end
  end

  // Programming sequencer
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
      addr_q <= 16'h0000;
      wdata_q <= 16'hffff;
      cmd_q <= 4'h0;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      read_drv_q <= 1'b0;
      word_verify_ok_o <= 1'b0;
      cumulative_verify_ok_o <= 1'b0;
      programming_active_n_o <= 1'b1;
      fetch_rd_n_o <= 1'b1;
    end else begin
      wr_q <= 1'b0;
      if (!started_q) begin
        cumulative_verify_ok_o <= 1'b1;
        word_verify_ok_o <= 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          // Command or address latched from both bus bytes
          if (slave_q && cmd_rise) begin
            cmd_q <= bus_s[15:12];
            // Every command word carries its address in the low bits
            addr_q <= {4'h0, bus_s[11:0]};
            read_drv_q <= (bus_s[15:12] == `OPP_CMD_READ);
          end else if (slave_q && program_start_n_rise) begin
            wdata_q <= bus_s;
            read_drv_q <= 1'b0;
            cnt_q <= 8'h00;
            st_q <= ST_PULSE;
          end else if (auto_q && started_q &&
                       addr_q <= `OPP_AUTO_LAST) begin
            programming_active_n_o <= 1'b0;
            fetch_rd_n_o <= 1'b0;
            cnt_q <= 8'h00;
            st_q <= ST_AFETCH;
          end
        end
        ST_AFETCH: begin
          // Word arrives from external memory over the bus
          wdata_q <= bus_s;
          fetch_rd_n_o <= 1'b1;
          st_q <= ST_PULSE;
        end
        ST_PULSE: begin
          if (slave_q && program_start_n_fall) begin
            st_q <= ST_VERIFY;
          end else if (cnt_q == PULSE_CYC - 8'h01) begin
            wr_q <= 1'b1;
            if (auto_q) begin
              st_q <= ST_ADATA;
            end
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_ADATA: begin
          st_q <= ST_VERIFY;
        end
        ST_VERIFY: begin
          word_verify_ok_o <= verify_ok;
          if (!verify_ok) begin
            word_verify_ok_o <= 1'b0;
            cumulative_verify_ok_o <= 1'b0;
          end
          if (auto_q) begin
            if (addr_q == `OPP_AUTO_LAST) begin
              programming_active_n_o <= 1'b1;
              st_q <= ST_DONE;
            end else begin
              addr_q <= addr_q + 16'h0001;
              st_q <= ST_IDLE;
            end
          end else begin
            if (!step_n_s) begin
              addr_q <= addr_q + 16'h0001;
            end
            st_q <= ST_IDLE;
          end
        end
        ST_DONE: begin
          programming_active_n_o <= 1'b1;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Open-drain drive: only zeros are pulled, far side pulls up
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      program_bus_o <= 16'h0000;
      program_bus_oe_n_o <= 16'hffff;
    end else begin
      program_bus_o <= 16'h0000;
      // Read drive lets go while a new command is being latched
      if (slave_q && read_drv_q && cmd_n_s) begin
        program_bus_oe_n_o <= rdata;
      end else begin
        program_bus_oe_n_o <= 16'hffff;
      end
    end
  end
endmodule

// file: core/opp_defs.vh
`ifndef OPP_DEFS_VH
`define OPP_DEFS_VH
// How it works
// - Low command-latch strobe means both bus bytes hold a command or address.
// - In slave mode, rising program-start edge latches bus data and starts programming.
// - Falling program-start edge ends the programming operation.
// - In programming modes, word-verify is high when the word wrote correctly; in auto mode the code compares the data with the word as read before its write.
// - Word-verify low after program-start falling edge signals a programming error.
// - In auto mode, programming-active is held low while programming runs.
// - Sixteen-bit open-drain program bus; low byte port 3, high byte port 4.
// - In auto mode the program bus fetches from external memory as a bus.
// - In slave mode the program bus acts as open-drain port pins.
// - Four-bit algorithm select is sampled after reset when access pin is low.
// - In auto mode, port 1 pins carry bus bits fifteen to twelve.
// - Auto-step input low advances the address after each slave-mode programming operation.
// - Cumulative verify high from entry until first error, then low until exit.
// - Access pin at programming level at reset release enters the selected mode.

// Algorithm select codes
`define OPP_ALG_SLAVE 4'hc
`define OPP_ALG_AUTO 4'h5
`define OPP_ALG_DUMP 4'h6
// Slave commands in the high nibble of a latched command word
`define OPP_CMD_WRITE 4'h1
`define OPP_CMD_READ 4'h2
`define OPP_CMD_ADDR 4'h3
// Programming pulse time in ns and its cycle count at 4 ns
`define OPP_PULSE_NS 100
`define OPP_CLK_NS 4
`define OPP_PULSE_CYC ((`OPP_PULSE_NS + `OPP_CLK_NS - 1) / `OPP_CLK_NS)
// Auto mode bounds
`define OPP_AUTO_LAST 16'h7fff
`define OPP_ARRAY_WORDS 4096
`endif

// file: core/opp_sync.v
`timescale 1ns/1ns
`include "opp_defs.vh"
// Two-stage synchroniser for a vector of pin inputs
module opp_sync #(
  parameter W = 1
) (
  // Clock and reset
  input wire clock_i,
  input wire rst_b_i,
  // Data
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  // Only the second stage reads the first
  always @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_q <= {W{1'b1}};
      q_o <= {W{1'b1}};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// file: core/opp_array.v
`timescale 1ns/1ns
`include "opp_defs.vh"
// One-time programmable word array: bits only go from one to zero
module opp_array #(
  parameter AW = 12
) (
  // Clock
  input wire clock_i,
  // Program port
  input wire wr_i,
  input wire [AW-1:0] addr_i,
  input wire [15:0] wdata_i,
  // Read port
  output reg [15:0] rdata_o
);
  reg [15:0] mem [0:(1<<AW)-1];
  integer i;

  // Blank array reads all ones
  initial begin
    for (i = 0; i < (1 << AW); i = i + 1) begin
      mem[i] = 16'hffff;
    end
  end

  // Programming can only clear bits
  always @(posedge clock_i) begin
    if (wr_i) begin
      mem[addr_i] <= mem[addr_i] & wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule

// file: bench/opp_program_start_n_port_checker.sv
`timescale 1ns/1ns
`include "opp_defs.vh"
// Watches the programming port pins
module opp_program_start_n_port_checker (
  // Clock and reset
  input wire clock_i,
  input wire rst_b_i,
  // Pins in
  input wire external_access_n_i,
  input wire [3:0] program_algorithm_select_i,
  input wire program_start_n_cmd_latch_n_i,
  input wire program_start_n_i,
  input wire auto_address_step_n_i,
  input wire [15:0] program_bus_i,
  // Pins out
  input wire [15:0] program_bus_o,
  input wire [15:0] program_bus_oe_n_o,
  input wire fetch_rd_n_o,
  input wire word_verify_ok_o,
  input wire cumulative_verify_ok_o,
  input wire programming_active_n_o,
  input wire program_start_n_mode_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  // Mode, bus and status relations
  property p_enter;
    $rose(rst_b_i) && !external_access_n_i |-> ##[0:3] program_start_n_mode_o;
  endproperty
  a_enter: assert property (p_enter) else $error("no mode entry");
  property p_drain;
    program_bus_o == 16'h0000;
  endproperty
  a_drain: assert property (p_drain) else $error("bus driven high");
  property p_float;
    !program_start_n_mode_o |-> program_bus_oe_n_o == 16'hffff;
  endproperty
  a_float: assert property (p_float) else $error("bus pulled");
  property p_cum_hold;
    program_start_n_mode_o && !cumulative_verify_ok_o |=> !cumulative_verify_ok_o;
  endproperty
  a_cum_hold: assert property (p_cum_hold) else $error("cum rose");
  property p_cum_err;
    program_start_n_mode_o && $fell(word_verify_ok_o) |-> ##[0:1]
      !cumulative_verify_ok_o;
  endproperty
  a_cum_err: assert property (p_cum_err) else $error("cum missed");
  property p_act_auto;
    !programming_active_n_o |-> program_algorithm_select_i == `OPP_ALG_AUTO;
  endproperty
  a_act_auto: assert property (p_act_auto) else $error("active");
  property p_fetch_auto;
    !fetch_rd_n_o |-> program_start_n_mode_o && !programming_active_n_o;
  endproperty
  a_fetch_auto: assert property (p_fetch_auto) else $error("fetch");
  property p_fetch_pulse;
    !fetch_rd_n_o |=> fetch_rd_n_o;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("long");
endmodule

// file: bench/opp_program_start_n_host.sv
`timescale 1ns/1ns
// Programmer side of the open-drain bus, with pull-ups
module opp_program_start_n_host (
  // Device side
  input wire [15:0] dev_data_i,
  input wire [15:0] dev_oe_n_i,
  // Programmer drive, a low bit pulls the line low
  input wire [15:0] host_drive_i,
  // Line level
  output wire [15:0] bus_o
);
  // Any party pulling low wins, else the pull-up holds high
  assign bus_o = host_drive_i & (dev_oe_n_i | dev_data_i);
endmodule

// file: bench/opp_program_start_n_port_tb.sv
`timescale 1ns/1ns
`include "opp_defs.vh"
// Programmer session against the port
module opp_program_start_n_port_tb;
  reg clock_i = 0, rst_b_i = 0, external_access_n_i = 0;
  reg [3:0] program_algorithm_select_i = `OPP_ALG_SLAVE;
  reg program_start_n_cmd_latch_n_i = 1, program_start_n_i = 0;
  reg auto_address_step_n_i = 1;
  reg [15:0] drive = 16'hffff;
  wire [15:0] program_bus_i, program_bus_o, program_bus_oe_n_o;
  wire fetch_rd_n_o, word_verify_ok_o, cumulative_verify_ok_o;
  wire programming_active_n_o, program_start_n_mode_o;
  integer errors = 0, checks_done = 0, i;
  reg [11:0] base;
  reg [15:0] d [0:2];
  opp_program_start_n_port opp_program_start_n_port_inst (.*);
  opp_program_start_n_host opp_program_start_n_host_inst (.dev_data_i(program_bus_o),
    .dev_oe_n_i(program_bus_oe_n_o), .host_drive_i(drive),
    .bus_o(program_bus_i));
  // Clock at 4 ns
  always #2 clock_i = ~clock_i;
  // Compare and count
  task chk(input string n, input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clock_i);
  endtask
  // Reset with straps held across the release
  task boot(input logic ea, input logic [3:0] sel);
    cyc(1);
    rst_b_i = 0;
    external_access_n_i = ea;
    program_algorithm_select_i = sel;
    cyc(6);
    rst_b_i = 1;
    cyc(6);
  endtask
  // Latch a command word
  task cmd(input logic [15:0] w);
    drive = w;
    program_start_n_cmd_latch_n_i = 0;
    cyc(4);
    program_start_n_cmd_latch_n_i = 1;
    cyc(4);
    drive = 16'hffff;
    cyc(4);
  endtask
  // Program one word and check the verify outputs
  task program_start_n(input logic [15:0] w, input logic ok, cum);
    drive = w;
    program_start_n_i = 1;
    cyc(30);
    program_start_n_i = 0;
    cyc(6);
    drive = 16'hffff;
    chk("verify", word_verify_ok_o, ok);
    chk("cumulative", cumulative_verify_ok_o, cum);
  endtask
  initial begin
    i = $urandom(32'h6a41);
    boot(0, `OPP_ALG_SLAVE);
    chk("mode", program_start_n_mode_o, 1);
    base = 12'($urandom % 4080);
    for (i = 0; i < 2; i++) d[i] = 16'($urandom) & 16'hfffe;
    d[2] = 16'h0000;
    // Three words from one address through the auto step
    cmd({`OPP_CMD_ADDR, base});
    auto_address_step_n_i = 0;
    for (i = 0; i < 3; i++) program_start_n(d[i], 1, 1);
    auto_address_step_n_i = 1;
    // Setting a cleared bit back fails, and the error sticks
    cmd({`OPP_CMD_ADDR, base});
    program_start_n(16'hffff, 0, 0);
    cmd({`OPP_CMD_ADDR, base + 12'd5});
    program_start_n(d[1], 1, 0);
    $display("test slave writes done");
    // Dump the words back through the pull-ups
    boot(0, `OPP_ALG_DUMP);
    for (i = 0; i < 3; i++) begin
      cmd({`OPP_CMD_READ, base + i[11:0]});
      chk("dump", program_bus_i, d[i]);
    end
    $display("test dump done");
    boot(1, `OPP_ALG_SLAVE);
    chk("normal", program_start_n_mode_o, 0);
    cmd({`OPP_CMD_READ, base});
    chk("idle bus", program_bus_oe_n_o, 16'hffff);
    boot(0, `OPP_ALG_AUTO);
    i = 0;
    while (programming_active_n_o && i < 300) begin
      cyc(1);
      i++;
    end
    chk("active", programming_active_n_o, 0);
    $display("test modes done");
    end_sim;
  end
  // Watchdog
  initial begin
    #200000;
    errors++;
    end_sim;
  end
endmodule
bind opp_program_start_n_port opp_program_start_n_port_checker opp_program_start_n_port_checker_inst (.*);
